//--- rtl/sqde_pkg.sv
package sqde_pkg;
    // ----------------------------------------------------------
    // widths, offsets and fields
    // ----------------------------------------------------------
    localparam int ZW = 18;  // impedance, 0.01 ohm signed
    localparam int CW = 12;  // current, 0.01 A
    localparam int PW = 10;  // pickup, 0.01 A
    localparam int FW = 8;   // factor, 0.01 units
    localparam int AW = 4;
    localparam int DW = 32;
    localparam logic [AW-1:0] SQDE_CTRL_OFS  = 4'h0;
    localparam logic [AW-1:0] SQDE_POS_SEQ_LINE_IMPEDANCE_MAGNITUDE_OFS = 4'h1;
    localparam logic [AW-1:0] SQDE_Z2F_OFS   = 4'h2;
    localparam logic [AW-1:0] SQDE_Z2R_OFS   = 4'h3;
    localparam logic [AW-1:0] SQDE_QPICK_OFS = 4'h4;
    localparam logic [AW-1:0] SQDE_GPICK_OFS = 4'h5;
    localparam logic [AW-1:0] SQDE_FACT_OFS  = 4'h6;
    localparam logic [AW-1:0] SQDE_ORDER_OFS = 4'h7;
    localparam logic [AW-1:0] SQDE_STAT_OFS  = 4'h8;
    localparam int CTRL_NOM1A_BIT = 4;
    localparam int CTRL_V300_BIT  = 5;
    localparam int PICK_REV_LSB   = 16;
    localparam int FAC_K2_LSB     = 8;
    localparam int FAC_A0_LSB     = 16;
    localparam int ST_PH_BIT = 0;
    localparam int ST_GND_BIT = 1;
    localparam int ST_ZERO_BIT = 2;
    localparam int ST_DET_LSB = 3;
    localparam int ST_ERR_BIT = 7;
    localparam int ST_SEL_LSB = 8;
    // ----------------------------------------------------------
    // limits, defaults and scale factors
    // ----------------------------------------------------------
    localparam logic [ZW-1:0] Z_LIM_5A_150 = 18'h01900; // 64.00
    localparam logic [ZW-1:0] Z_LIM_1A_150 = 18'h07d00; // 320.00
    localparam logic [ZW-1:0] Z_LIM_5A_300 = 18'h03200; // 128.00
    localparam logic [ZW-1:0] Z_LIM_1A_300 = 18'h0fa00; // 640.00
    localparam logic [ZW-1:0] Z_MARGIN     = 18'h0000a; // 0.1
    localparam logic [ZW-1:0] Z_OFS_5A_150 = 18'h0000a;
    localparam logic [ZW-1:0] Z_OFS_5A_300 = 18'h00014;
    localparam logic [ZW-1:0] Z_OFS_1A_150 = 18'h00032;
    localparam logic [ZW-1:0] Z_OFS_1A_300 = 18'h00064;
    localparam logic [PW-1:0] Q_MIN_5A = 10'h019, Q_MAX_5A = 10'h1f4;
    localparam logic [PW-1:0] Q_MIN_1A = 10'h005, Q_MAX_1A = 10'h064;
    localparam logic [PW-1:0] G_MIN_5A = 10'h005, G_MAX_5A = 10'h1f4;
    localparam logic [PW-1:0] G_MIN_1A = 10'h001, G_MAX_1A = 10'h064;
    localparam logic [PW-1:0] P_AUTO_F_5A = 10'h032, P_AUTO_R_5A = 10'h019;
    localparam logic [PW-1:0] P_AUTO_F_1A = 10'h00a, P_AUTO_R_1A = 10'h005;
    localparam logic [FW-1:0] A_MIN = 8'h02, A_MAX = 8'h32;
    localparam logic [FW-1:0] K2_MIN = 8'h0a, K2_MAX = 8'h78;
    localparam logic [FW-1:0] A2_AUTO = 8'h0a, K2_AUTO = 8'h14;
    localparam logic [FW-1:0] A0_AUTO = 8'h0a;
    localparam logic [CW-1:0] PCT = 12'h064;   // factor scale 100
    localparam logic [CW-1:0] SEQ_DIV = 12'h003; // 3I0 = IG
    // ----------------------------------------------------------
    // types
    // ----------------------------------------------------------
    typedef enum logic [2:0] {
        SQDE_OFF = 3'b001, SQDE_MAN = 3'b010, SQDE_AUTO = 3'b100
    } sqde_mode_e;
    typedef enum logic [1:0] {
        SQDE_EL_NONE = 2'h0, SQDE_EL_Q = 2'h1, SQDE_EL_V = 2'h2, SQDE_EL_I = 2'h3
    } sqde_elem_e;
    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic          wr;
        logic          rd;
    } sqde_bus_s;
    typedef struct packed {
        logic [CW-1:0] i1_mag;  // |I1|
        logic [CW-1:0] i2_mag;  // |I2|
        logic [CW-1:0] ig_mag;  // |IA+IB+IC| = 3|I0|
        logic          ve;      // zero-seq voltage-pol enable
        logic          ie;      // neutral current-pol enable
    } sqde_meas_s;
    typedef struct packed {
        logic qf, qr, gf, gr;
    } sqde_det_s;
    typedef struct packed {
        sqde_mode_e        mode;
        logic              nom_1a, v300;
        logic [ZW-1:0]     pos_seq_line_impedance_magnitude;
        logic signed [ZW-1:0] z2f, z2r;
        logic [PW-1:0]     qfp, qrp, gfp, grp;
        logic [FW-1:0]     a2, k2, a0;
        sqde_elem_e [2:0]  order;
        logic              wr_err, ph_en, gnd_en, zero_en;
        logic [DW-1:0]     rdata;
        sqde_det_s         det;
        sqde_elem_e        sel;
    } sqde_state_s;
    localparam sqde_state_s SQDE_RST = '{
        mode: SQDE_AUTO, nom_1a: 1'b0, v300: 1'b0, pos_seq_line_impedance_magnitude: 18'h003e8,
        z2f: 18'sh001f4, z2r: 18'sh00258, qfp: P_AUTO_F_5A,
        qrp: P_AUTO_R_5A, gfp: P_AUTO_F_5A, grp: P_AUTO_R_5A,
        a2: A2_AUTO, k2: K2_AUTO, a0: A0_AUTO,
        order: '{SQDE_EL_NONE, SQDE_EL_V, SQDE_EL_Q},
        wr_err: 1'b0, ph_en: 1'b0, gnd_en: 1'b0, zero_en: 1'b0,
        rdata: 32'h0, det: 4'h0, sel: SQDE_EL_NONE};
endpackage

//--- rtl/sqde_top.sv
module sqde_top
    import sqde_pkg::*;
(
    input  wire logic       clk_in,        // 50 MHz clock
    input  wire logic       arst_n_in,     // async reset, low
    input  wire sqde_bus_s  bus_in,        // register request
    input  wire sqde_meas_s meas_in,       // magnitudes, same clock
    output logic [DW-1:0]   rdata_out,     // read data
    output logic            phase_en_out,  // phase path enable
    output logic            ground_en_out, // ground path enable
    output logic            zero_en_out,   // zero-seq enable
    output sqde_det_s       det_out,       // fault detectors
    output sqde_elem_e      sel_out        // chosen ground element
);
    // ----------------------------------------------------------
    // helpers
    // ----------------------------------------------------------
    function automatic logic rng_ok(input logic [ZW-1:0] v,
                                    input logic [ZW-1:0] lo,
                                    input logic [ZW-1:0] hi);
        rng_ok = (v >= lo) && (v <= hi);
    endfunction

    function automatic logic z_ok(input logic signed [ZW-1:0] v,
                                  input logic [ZW-1:0] lim);
        logic signed [ZW:0] l;
        l = $signed({1'b0, lim});
        z_ok = (v <= l) && (v >= -l);
    endfunction

    function automatic logic has_zero_f(input sqde_elem_e [2:0] ord);
        has_zero_f = 1'b0;
        for (int i = 0; i < 3; i++) begin
            if (ord[i] == SQDE_EL_V || ord[i] == SQDE_EL_I) begin
                has_zero_f = 1'b1;
            end
        end
    endfunction

    function automatic logic [23:0] mul(input logic [CW-1:0] a,
                                        input logic [CW-1:0] b);
        mul = 24'(a) * 24'(b);
    endfunction

    sqde_state_s          s_reg;
    sqde_state_s          s_next;
    logic                 auto_m;
    logic                 mode_on;
    logic                 has_zero;
    logic [ZW-1:0]        zlim;
    logic [ZW-1:0]        zofs;
    logic [ZW-1:0]        half;
    logic signed [ZW-1:0] z2f_eff;
    logic signed [ZW-1:0] z2r_eff;
    logic [PW-1:0]        qfp_eff, qrp_eff, gfp_eff, grp_eff;
    logic [PW-1:0]        qmin, qmax, gmin, gmax;
    logic [FW-1:0]        a2_eff, k2_eff, a0_eff;
    logic [CW-1:0]        a0x3;
    logic                 ph_cmp, k2_cmp, zr_cmp, gnd_cmp;
    sqde_det_s            det_cmp;
    sqde_elem_e           sel_cmp;
    logic signed [ZW-1:0] wz;

    assign auto_m   = (s_reg.mode == SQDE_AUTO);
    assign mode_on  = (s_reg.mode != SQDE_OFF);
    assign has_zero = has_zero_f(s_reg.order);
    assign wz       = $signed(bus_in.wdata[ZW-1:0]);
    assign half     = s_reg.pos_seq_line_impedance_magnitude >> 1;

    // ----------------------------------------------------------
    // rating-dependent limits and effective settings
    // ----------------------------------------------------------
    // auto values are muxed in rather than written over the stored
    // ones, so leaving auto mode restores the user entries
    always_comb begin
        case ({s_reg.nom_1a, s_reg.v300})
            2'b00: begin zlim = Z_LIM_5A_150; zofs = Z_OFS_5A_150; end
            2'b01: begin zlim = Z_LIM_5A_300; zofs = Z_OFS_5A_300; end
            2'b10: begin zlim = Z_LIM_1A_150; zofs = Z_OFS_1A_150; end
            default: begin zlim = Z_LIM_1A_300; zofs = Z_OFS_1A_300; end
        endcase
        qmin = s_reg.nom_1a ? Q_MIN_1A : Q_MIN_5A;
        qmax = s_reg.nom_1a ? Q_MAX_1A : Q_MAX_5A;
        gmin = s_reg.nom_1a ? G_MIN_1A : G_MIN_5A;
        gmax = s_reg.nom_1a ? G_MAX_1A : G_MAX_5A;
        if (auto_m) begin
            z2f_eff = $signed(half);
            z2r_eff = $signed(ZW'(half + zofs));
            qfp_eff = s_reg.nom_1a ? P_AUTO_F_1A : P_AUTO_F_5A;
            qrp_eff = s_reg.nom_1a ? P_AUTO_R_1A : P_AUTO_R_5A;
            gfp_eff = qfp_eff;
            grp_eff = qrp_eff;
            a2_eff = A2_AUTO;
            k2_eff = K2_AUTO;
            a0_eff = A0_AUTO;
        end else begin
            z2f_eff = s_reg.z2f;
            z2r_eff = s_reg.z2r;
            qfp_eff = s_reg.qfp;
            qrp_eff = s_reg.qrp;
            gfp_eff = s_reg.gfp;
            grp_eff = s_reg.grp;
            a2_eff = s_reg.a2;
            k2_eff = s_reg.k2;
            a0_eff = s_reg.a0;
        end
    end

    // ----------------------------------------------------------
    // magnitude comparisons and ground priority
    // ----------------------------------------------------------
    // factors are in hundredths, so |I2| is scaled by 100; the I0
    // ratio folds the divide by 3 into the other side (no divider)
    always_comb begin
        a0x3 = CW'({4'h0, a0_eff} * SEQ_DIV);
        ph_cmp = mul(PCT, meas_in.i2_mag)
                 > mul({4'h0, a2_eff}, meas_in.i1_mag);
        k2_cmp = mul(CW'(PCT * SEQ_DIV), meas_in.i2_mag)
                 > mul({4'h0, k2_eff}, meas_in.ig_mag);
        zr_cmp = mul(PCT, meas_in.ig_mag)
                 > mul(a0x3, meas_in.i1_mag);
        gnd_cmp = ph_cmp && (k2_cmp || !(meas_in.ve || meas_in.ie));
        det_cmp.qf = mul(SEQ_DIV, meas_in.i2_mag) > 24'(qfp_eff);
        det_cmp.qr = mul(SEQ_DIV, meas_in.i2_mag) > 24'(qrp_eff);
        det_cmp.gf = has_zero && (24'(meas_in.ig_mag) > 24'(gfp_eff));
        det_cmp.gr = has_zero && (24'(meas_in.ig_mag) > 24'(grp_eff));
        sel_cmp = SQDE_EL_NONE;
        for (int i = 2; i >= 0; i--) begin
            if ((s_reg.order[i] == SQDE_EL_Q && gnd_cmp)
                || (s_reg.order[i] == SQDE_EL_V && meas_in.ve && zr_cmp)
                || (s_reg.order[i] == SQDE_EL_I && meas_in.ie && zr_cmp)) begin
                sel_cmp = s_reg.order[i];
            end
        end
    end

    // ----------------------------------------------------------
    // register port and next state
    // ----------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.rdata = '0;
        s_next.ph_en = mode_on && ph_cmp;
        s_next.gnd_en = mode_on && gnd_cmp;
        s_next.zero_en = mode_on && zr_cmp;
        s_next.det = mode_on ? det_cmp : '0;
        s_next.sel = mode_on ? sel_cmp : SQDE_EL_NONE;
        if (bus_in.wr) begin
            s_next.wr_err = 1'b1;
            if (bus_in.addr == SQDE_CTRL_OFS) begin
                if (bus_in.wdata[2:0] == SQDE_OFF || bus_in.wdata[2:0] == SQDE_MAN
                    || bus_in.wdata[2:0] == SQDE_AUTO) begin
                    s_next.mode = sqde_mode_e'(bus_in.wdata[2:0]);
                    s_next.nom_1a = bus_in.wdata[CTRL_NOM1A_BIT];
                    s_next.v300 = bus_in.wdata[CTRL_V300_BIT];
                    s_next.wr_err = 1'b0;
                end
            end else if (bus_in.addr == SQDE_POS_SEQ_LINE_IMPEDANCE_MAGNITUDE_OFS) begin
                if (bus_in.wdata[ZW-1:0] <= zlim) begin
                    s_next.pos_seq_line_impedance_magnitude = bus_in.wdata[ZW-1:0];
                    s_next.wr_err = 1'b0;
                end
            end else if (bus_in.addr == SQDE_Z2F_OFS) begin
                if (z_ok(wz, zlim)
                    && s_reg.z2r >= wz + $signed({1'b0, Z_MARGIN})) begin
                    s_next.z2f = wz;
                    s_next.wr_err = 1'b0;
                end
            end else if (bus_in.addr == SQDE_Z2R_OFS) begin
                if (z_ok(wz, zlim)
                    && wz >= s_reg.z2f + $signed({1'b0, Z_MARGIN})) begin
                    s_next.z2r = wz;
                    s_next.wr_err = 1'b0;
                end
            end else if (bus_in.addr == SQDE_QPICK_OFS) begin
                if (rng_ok(ZW'(bus_in.wdata[PW-1:0]), ZW'(qmin), ZW'(qmax))
                    && rng_ok(ZW'(bus_in.wdata[PICK_REV_LSB+:PW]),
                              ZW'(qmin), ZW'(qmax))) begin
                    s_next.qfp = bus_in.wdata[PW-1:0];
                    s_next.qrp = bus_in.wdata[PICK_REV_LSB+:PW];
                    s_next.wr_err = 1'b0;
                end
            end else if (bus_in.addr == SQDE_GPICK_OFS) begin
                if (has_zero
                    && rng_ok(ZW'(bus_in.wdata[PW-1:0]), ZW'(gmin), ZW'(gmax))
                    && rng_ok(ZW'(bus_in.wdata[PICK_REV_LSB+:PW]),
                              ZW'(gmin), ZW'(gmax))) begin
                    s_next.gfp = bus_in.wdata[PW-1:0];
                    s_next.grp = bus_in.wdata[PICK_REV_LSB+:PW];
                    s_next.wr_err = 1'b0;
                end
            end else if (bus_in.addr == SQDE_FACT_OFS) begin
                if (rng_ok(ZW'(bus_in.wdata[FW-1:0]), ZW'(A_MIN), ZW'(A_MAX))
                    && rng_ok(ZW'(bus_in.wdata[FAC_K2_LSB+:FW]),
                              ZW'(K2_MIN), ZW'(K2_MAX))
                    && (!has_zero
                        || rng_ok(ZW'(bus_in.wdata[FAC_A0_LSB+:FW]),
                                  ZW'(A_MIN), ZW'(A_MAX)))) begin
                    s_next.a2 = bus_in.wdata[FW-1:0];
                    s_next.k2 = bus_in.wdata[FAC_K2_LSB+:FW];
                    if (has_zero) begin
                        s_next.a0 = bus_in.wdata[FAC_A0_LSB+:FW];
                    end
                    s_next.wr_err = 1'b0;
                end
            end else if (bus_in.addr == SQDE_ORDER_OFS) begin
                // slot by slot, so each code lands as an element code
                s_next.order = {sqde_elem_e'(bus_in.wdata[5:4]),
                                sqde_elem_e'(bus_in.wdata[3:2]),
                                sqde_elem_e'(bus_in.wdata[1:0])};
                s_next.wr_err = 1'b0;
            end
        end
        // reads show the values in use, not the entered ones
        if (bus_in.rd) begin
            if (bus_in.addr == SQDE_CTRL_OFS) begin
                s_next.rdata[2:0] = s_reg.mode;
                s_next.rdata[CTRL_NOM1A_BIT] = s_reg.nom_1a;
                s_next.rdata[CTRL_V300_BIT] = s_reg.v300;
            end else if (bus_in.addr == SQDE_POS_SEQ_LINE_IMPEDANCE_MAGNITUDE_OFS) begin
                s_next.rdata = DW'(s_reg.pos_seq_line_impedance_magnitude);
            end else if (bus_in.addr == SQDE_Z2F_OFS) begin
                s_next.rdata = DW'(z2f_eff);
            end else if (bus_in.addr == SQDE_Z2R_OFS) begin
                s_next.rdata = DW'(z2r_eff);
            end else if (bus_in.addr == SQDE_QPICK_OFS) begin
                s_next.rdata[PW-1:0] = qfp_eff;
                s_next.rdata[PICK_REV_LSB+:PW] = qrp_eff;
            end else if (bus_in.addr == SQDE_GPICK_OFS && has_zero) begin
                s_next.rdata[PW-1:0] = gfp_eff;
                s_next.rdata[PICK_REV_LSB+:PW] = grp_eff;
            end else if (bus_in.addr == SQDE_FACT_OFS) begin
                s_next.rdata[FW-1:0] = a2_eff;
                s_next.rdata[FAC_K2_LSB+:FW] = k2_eff;
                s_next.rdata[FAC_A0_LSB+:FW] = has_zero ? a0_eff : '0;
            end else if (bus_in.addr == SQDE_ORDER_OFS) begin
                s_next.rdata[5:0] = s_reg.order;
            end else if (bus_in.addr == SQDE_STAT_OFS) begin
                s_next.rdata[ST_PH_BIT] = s_reg.ph_en;
                s_next.rdata[ST_GND_BIT] = s_reg.gnd_en;
                s_next.rdata[ST_ZERO_BIT] = s_reg.zero_en;
                s_next.rdata[ST_DET_LSB+:4] = s_reg.det;
                s_next.rdata[ST_ERR_BIT] = s_reg.wr_err;
                s_next.rdata[ST_SEL_LSB+:2] = s_reg.sel;
            end
        end
    end

    // state register
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s_reg <= SQDE_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rdata_out     = s_reg.rdata;
    assign phase_en_out  = s_reg.ph_en;
    assign ground_en_out = s_reg.gnd_en;
    assign zero_en_out   = s_reg.zero_en;
    assign det_out       = s_reg.det;
    assign sel_out       = s_reg.sel;

    // ----------------------------------------------------------
    // checks
    // ----------------------------------------------------------
    default clocking @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);

    sequence rd_auto_s(logic [AW-1:0] a);
        bus_in.rd && bus_in.addr == a && s_reg.mode == SQDE_AUTO;
    endsequence

    auto_fwd_z_a: assert property (rd_auto_s(SQDE_Z2F_OFS)
        |=> rdata_out[ZW-1:0] == ZW'($past(s_reg.pos_seq_line_impedance_magnitude) / 2))
        else $error("auto forward threshold wrong");
    auto_rev_z_a: assert property (rd_auto_s(SQDE_Z2R_OFS)
        |=> rdata_out[ZW-1:0] == ZW'($past(s_reg.pos_seq_line_impedance_magnitude) / 2
            + ($past(s_reg.nom_1a) ? ($past(s_reg.v300) ? Z_OFS_1A_300 : Z_OFS_1A_150)
                                   : ($past(s_reg.v300) ? Z_OFS_5A_300 : Z_OFS_5A_150))))
        else $error("auto reverse threshold wrong");
    z_margin_a: assert property (
        int'(s_reg.z2r) - int'(s_reg.z2f) >= int'(Z_MARGIN))
        else $error("reverse threshold margin lost");
    auto_pick_a: assert property (rd_auto_s(SQDE_QPICK_OFS)
        |=> rdata_out[PW-1:0] == ($past(s_reg.nom_1a) ? P_AUTO_F_1A : P_AUTO_F_5A)
            && rdata_out[PICK_REV_LSB+:PW]
               == ($past(s_reg.nom_1a) ? P_AUTO_R_1A : P_AUTO_R_5A))
        else $error("auto pickups wrong");
    phase_en_a: assert property (
        phase_en_out == ($past(mode_on) && 100 * int'($past(meas_in.i2_mag))
            > int'($past(a2_eff)) * int'($past(meas_in.i1_mag))))
        else $error("phase enable mismatch");
    ground_en_a: assert property (
        ground_en_out == ($past(mode_on) && 100 * int'($past(meas_in.i2_mag))
            > int'($past(a2_eff)) * int'($past(meas_in.i1_mag))
            && (!$past(meas_in.ve || meas_in.ie) || 300 * int'($past(meas_in.i2_mag))
                > int'($past(k2_eff)) * int'($past(meas_in.ig_mag)))))
        else $error("ground enable mismatch");
    zero_en_a: assert property (
        zero_en_out == ($past(mode_on) && 100 * int'($past(meas_in.ig_mag))
            > 3 * int'($past(a0_eff)) * int'($past(meas_in.i1_mag))))
        else $error("zero-seq enable mismatch");
    hidden_res_a: assert property ($past(!has_zero)
        |-> !det_out.gf && !det_out.gr)
        else $error("residual detector active while hidden");
    read_once_a: assert property (!$past(bus_in.rd) |-> rdata_out == '0)
        else $error("read data outside its cycle");
endmodule

//--- bench/sqde_meas_model.sv
module sqde_meas_model
    import sqde_pkg::*;
(
    input  wire logic          clk_in,   // system clock
    input  wire logic [CW-1:0] i1_in,    // positive-seq magnitude
    input  wire logic [CW-1:0] i2_in,    // negative-seq magnitude
    input  wire logic [CW-1:0] i0_in,    // zero-seq magnitude
    input  wire logic [1:0]    pol_in,   // {ve, ie}
    output sqde_meas_s         meas_out  // toward the block
);
    timeunit 1ns;
    timeprecision 1ns;
    // one stage of latency, as a phasor filter would add
    initial meas_out = '0;
    always @(posedge clk_in) begin
        meas_out <= '{i1_in, i2_in, CW'(3 * i0_in), pol_in[1], pol_in[0]};
    end
endmodule

//--- bench/test_sequence_directional_enable_settings.sv
module test_sequence_directional_enable_settings;
    timeunit 1ns;
    timeprecision 1ns;
    import sqde_pkg::*;
    logic          clk_in = 1'b0;
    logic          arst_n_in = 1'b0;
    sqde_bus_s     bus = '0;
    sqde_meas_s    meas;
    logic [CW-1:0] i1 = '0, i2 = '0, i0 = '0;
    logic [1:0]    pol = '0;
    logic [DW-1:0] rdata_out, v;
    logic          ph, gnd, zero;
    sqde_det_s     det;
    sqde_elem_e    sel;
    int            err_count = 0, n_tests = 0, cycles = 0;
    sqde_meas_model meas_mdl (.clk_in(clk_in), .i1_in(i1), .i2_in(i2), .i0_in(i0),
        .pol_in(pol), .meas_out(meas));
    sqde_top dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .bus_in(bus), .meas_in(meas),
        .rdata_out(rdata_out), .phase_en_out(ph), .ground_en_out(gnd),
        .zero_en_out(zero), .det_out(det), .sel_out(sel));
    // ------------------------------------------------------------
    // clock, timeout, shared tasks
    // ------------------------------------------------------------
    initial forever #10 clk_in = ~clk_in;
    // about a hundred cycles are needed; a hang stops well past that
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            wrap_up();
        end
    end
    task automatic chk(input string n, input logic [DW-1:0] e, input logic [DW-1:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge clk_in);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_in);
        bus <= '{a, d, 1'b0, 1'b0};
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
        @(posedge clk_in);
        bus <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk_in);
        bus <= '{a, 32'h0, 1'b0, 1'b0};
        #1 d = rdata_out;
    endtask
    task automatic err_chk(input logic e);
        rd(SQDE_STAT_OFS, v);
        chk("wr_err", {31'h0, e}, {31'h0, v[ST_ERR_BIT]});
    endtask
    // model adds one cycle, the block one more
    task automatic m_chk(input int a, b, c, input logic [1:0] p, input logic [8:0] e);
        @(posedge clk_in);
        i1 <= CW'(a);
        i2 <= CW'(b);
        i0 <= CW'(c);
        pol <= p;
        repeat (3) @(posedge clk_in);
        #1 chk("outputs", {23'h0, e}, {23'h0, ph, gnd, zero, det, sel});
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_auto();
        logic [DW-1:0] ofs [4] = '{32'd10, 32'd20, 32'd50, 32'd100};
        rd(SQDE_Z2F_OFS, v); chk("z2f", 32'd500, v);
        rd(SQDE_GPICK_OFS, v); chk("gpick", 32'h0019_0032, v);
        rd(SQDE_FACT_OFS, v); chk("fact", 32'h000a_140a, v);
        for (int i = 0; i < 4; i++) begin
            wr(SQDE_CTRL_OFS, 32'h4 | (32'(i / 2) << 4) | (32'(i % 2) << 5));
            rd(SQDE_Z2R_OFS, v); chk("z2r", 32'd500 + ofs[i], v);
        end
        rd(SQDE_QPICK_OFS, v); chk("qpick", 32'h0005_000a, v);
    endtask
    task automatic t_manual();
        wr(SQDE_CTRL_OFS, 32'h2);
        wr(SQDE_Z2F_OFS, 32'd100);
        wr(SQDE_Z2R_OFS, 32'd109);
        err_chk(1'b1);
        rd(SQDE_Z2R_OFS, v); chk("z2r", 32'd600, v);
        wr(SQDE_Z2R_OFS, 32'd110);
        err_chk(1'b0);
        wr(SQDE_Z2F_OFS, 32'hffff_e6ff);
        rd(SQDE_Z2F_OFS, v); chk("z2f", 32'd100, v);
        wr(SQDE_Z2F_OFS, 32'hffff_e700);
        rd(SQDE_Z2F_OFS, v); chk("z2f", 32'hffff_e700, v);
        wr(SQDE_CTRL_OFS, 32'h4);
        rd(SQDE_Z2F_OFS, v); chk("z2f", 32'd500, v);
        wr(SQDE_CTRL_OFS, 32'h2);
    endtask
    task automatic t_enables();
        wr(SQDE_FACT_OFS, 32'h000a_1414);
        m_chk(1000, 201, 0, 2'b00, 9'h1b1);
        m_chk(1000, 200, 0, 2'b00, 9'h030);
        m_chk(1000, 201, 1005, 2'b10, 9'h17e);
        m_chk(1000, 201, 1004, 2'b10, 9'h1fd);
        m_chk(1000, 201, 1005, 2'b00, 9'h1fd);
        wr(SQDE_ORDER_OFS, 32'h0d);
        m_chk(1000, 0, 100, 2'b01, 9'h00c);
        m_chk(1000, 0, 101, 2'b01, 9'h04f);
    endtask
    task automatic t_order();
        wr(SQDE_ORDER_OFS, 32'h1);
        rd(SQDE_GPICK_OFS, v); chk("gpick", 32'h0, v);
        wr(SQDE_GPICK_OFS, 32'h0019_0032);
        err_chk(1'b1);
        rd(SQDE_FACT_OFS, v); chk("fact", 32'h0000_1414, v);
        rd(4'h9, v); chk("unmapped", 32'h0, v);
        m_chk(1000, 201, 1005, 2'b00, 9'h1f1);
        wr(SQDE_CTRL_OFS, 32'h3);
        err_chk(1'b1);
        wr(SQDE_CTRL_OFS, 32'h1);
        m_chk(1000, 201, 1005, 2'b11, 9'h000);
    endtask
    initial begin
        repeat (6) @(posedge clk_in);
        arst_n_in <= 1'b1;
        t_auto();
        t_manual();
        t_enables();
        t_order();
        wrap_up();
    end
endmodule
